/* hw/cgcfg_host.sv */
// cgcfg_host.sv: link master that runs block transfers ordered over APB
// assumes: one device on the link, software keeps pump codes consistent
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cgcfg_defines.svh"
module cgcfg_host #(
  parameter int QTR_CYC = `CGCFG_QTR_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial link
  cgcfg_if.host link
);
  import cgcfg_pkg::*;

  if (QTR_CYC < 2 || QTR_CYC > 65535)
  begin : g_bad_qtr
    $error("QTR_CYC out of range");
  end

  cgcfg_hst_st_t r_reg;
  cgcfg_hst_st_t r_next;
  logic tick;
  logic wr;
  logic [2:0] nidx;

  assign tick = (r_reg.div == 16'(QTR_CYC - 1));
  assign wr = psel_i & penable_i & pwrite_i;
  assign nidx = r_reg.idx + 3'h1;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // APB registers, quarter-bit divider and bit sequencer
  always_comb
  begin
    r_next = r_reg;
    r_next.div = tick ? 16'h0000 : r_reg.div + 16'h0001;
    // setup cycle latches the read answer
    if (psel_i && !penable_i)
    begin
      r_next.slverr = 1'b0;
      case (paddr_i)
        `CGCFG_OFS_CMD:
          r_next.prdata = {15'h0000, r_reg.rdcmd, 5'h00, r_reg.len,
            r_reg.ptr};
        `CGCFG_OFS_STAT:
          r_next.prdata = {29'h00000000, r_reg.done, r_reg.nack,
            r_reg.busy};
        `CGCFG_OFS_DATA: r_next.prdata = r_reg.data;
        default:
        begin
          r_next.prdata = 32'h00000000;
          r_next.slverr = 1'b1;
        end
      endcase
    end
    // access cycle commits writes, ignored while busy
    if (wr && !r_reg.busy)
    begin
      if (paddr_i == `CGCFG_OFS_DATA)
        r_next.data = pwdata_i;
      if (paddr_i == `CGCFG_OFS_CMD)
      begin
        r_next.ptr = pwdata_i[7:0];
        r_next.len = pwdata_i[`CGCFG_CMD_LEN_LSB +: 3];
        if (r_next.len > `CGCFG_MAX_LEN)
          r_next.len = `CGCFG_MAX_LEN;
        r_next.rdcmd = pwdata_i[`CGCFG_CMD_RD_BIT];
        if (pwdata_i[`CGCFG_CMD_GO_BIT])
        begin
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.nack = 1'b0;
          r_next.rsent = 1'b0;
          r_next.stg = STG_ADDR;
          r_next.q = 2'h0;
          r_next.st = HS_START;
        end
      end
    end
    if (tick && r_reg.st != HS_IDLE)
    begin
      r_next.q = r_reg.q + 2'h1;
      case (r_reg.st)
        HS_START:
        begin
          case (r_reg.q)
            2'h0:
            begin
              r_next.sda = 1'b1;
              r_next.scl = 1'b0;
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.sda = 1'b0;
            default:
            begin
              r_next.scl = 1'b0;
              r_next.st = HS_BYTE;
              r_next.bitn = 4'h0;
              r_next.rdb = 1'b0;
              r_next.sh = {`CGCFG_SLAVE_ADDR, r_reg.rsent};
            end
          endcase
        end
        HS_BYTE:
        begin
          case (r_reg.q)
            2'h0:
            begin
              r_next.scl = 1'b0;
              if (r_reg.bitn != 4'h8)
                r_next.sda = r_reg.rdb | r_reg.sh[7];
              else
                r_next.sda = ~r_reg.rdb | r_reg.ackb;
            end
            2'h1: r_next.scl = 1'b1;
            2'h2:
            begin
              if (r_reg.bitn != 4'h8)
                r_next.sh = {r_reg.sh[6:0], link.serial_data_pin};
              else if (!r_reg.rdb)
                r_next.ackb = link.serial_data_pin;
            end
            default:
            begin
              r_next.scl = 1'b0;
              r_next.bitn = r_reg.bitn + 4'h1;
              if (r_reg.bitn == 4'h8)
              begin
                r_next.bitn = 4'h0;
                if (!r_reg.rdb && r_reg.ackb)
                begin
                  r_next.nack = 1'b1;
                  r_next.st = HS_STOP;
                end
                else
                begin
                  case (r_reg.stg)
                    STG_ADDR:
                    begin
                      if (r_reg.rsent)
                      begin
                        r_next.stg = STG_DATA;
                        r_next.idx = 3'h0;
                        r_next.rdb = 1'b1;
                        r_next.ackb = (r_reg.len == 3'h1);
                      end
                      else
                      begin
                        r_next.stg = STG_PTR;
                        r_next.sh = r_reg.ptr;
                      end
                    end
                    STG_PTR:
                    begin
                      if (r_reg.len == 3'h0)
                        r_next.st = HS_STOP;
                      else if (r_reg.rdcmd)
                      begin
                        r_next.rsent = 1'b1;
                        r_next.stg = STG_ADDR;
                        r_next.st = HS_START;
                      end
                      else
                      begin
                        r_next.stg = STG_DATA;
                        r_next.idx = 3'h0;
                        r_next.sh = r_reg.data[7:0];
                      end
                    end
                    default:
                    begin
                      if (r_reg.rdb)
                        r_next.data[{r_reg.idx[1:0], 3'h0} +: 8] =
                          r_reg.sh;
                      r_next.idx = nidx;
                      r_next.ackb = (nidx + 3'h1 == r_reg.len);
                      r_next.sh = r_reg.data[{nidx[1:0], 3'h0} +: 8];
                      if (nidx == r_reg.len)
                        r_next.st = HS_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
        default:
        begin
          case (r_reg.q)
            2'h0:
            begin
              r_next.sda = 1'b0;
              r_next.scl = 1'b0;
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.sda = 1'b1;
            default:
            begin
              r_next.st = HS_IDLE;
              r_next.busy = 1'b0;
              r_next.done = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      r_reg <= '0;
      r_reg.scl <= 1'b1;
      r_reg.sda <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = r_reg.prdata;
  assign pslverr_o = r_reg.slverr;
  assign pready_o = 1'b1;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~r_reg.scl;
  assign link.msda_o = 1'b0;
  assign link.msda_oe = ~r_reg.sda;
endmodule // cgcfg_host
`default_nettype wire

/* hw/cgcfg_defines.svh */
// cgcfg_defines.svh: constants of the clock generator configuration link
// assumes: included by bare name
`ifndef CGCFG_DEFINES_SVH
`define CGCFG_DEFINES_SVH
// ----------------------------------------------------------------
// link and byte map
// ----------------------------------------------------------------
`define CGCFG_SLAVE_ADDR 7'h6E
`define CGCFG_NUM_BYTES 8'h18
`define CGCFG_BYTE_FB 5'h00
`define CGCFG_BYTE_ODIV 5'h04
`define CGCFG_BYTE_CTL 5'h08
`define CGCFG_BYTE_STYLE 5'h0C
`define CGCFG_BYTE_OE 5'h10
`define CGCFG_SKIP_BIT 6
`define CGCFG_PS_MSB 5
`define CGCFG_PS_LSB 4
`define CGCFG_PDIV_MSB 3
`define CGCFG_PDIV_LSB 2
`define CGCFG_CP_MSB 1
`define CGCFG_CP_LSB 0
`define CGCFG_Q0_BIT 1
`define CGCFG_Q1_BIT 2
`define CGCFG_Q2_BIT 5
`define CGCFG_Q3_BIT 6
`define CGCFG_FB_MIN 8'h08
`define CGCFG_FB_MAX 8'h7D
`define CGCFG_CFG_RESET 192'h00000000_66666666_66666666_21212121_04040404_32323232
// ----------------------------------------------------------------
// controller timing and register offsets
// ----------------------------------------------------------------
`define CGCFG_CLK_HZ 25000000
`define CGCFG_SCL_HZ 100000
`define CGCFG_QTR_CYC (`CGCFG_CLK_HZ / (4 * `CGCFG_SCL_HZ))
`define CGCFG_OFS_CMD 8'h00
`define CGCFG_OFS_STAT 8'h04
`define CGCFG_OFS_DATA 8'h08
`define CGCFG_CMD_GO_BIT 31
`define CGCFG_CMD_RD_BIT 16
`define CGCFG_CMD_LEN_LSB 8
`define CGCFG_MAX_LEN 3'h4
`endif

/* hw/cgcfg_pkg.sv */
// cgcfg_pkg.sv: types shared by both ends of the configuration link
// assumes: constants come from cgcfg_defines.svh
package cgcfg_pkg;
  // prescaler factor
  typedef enum logic [1:0] {PS_X1, PS_HALF, PS_X2} cgcfg_pscale_t;
  // device serial engine states
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_PTR, DS_WR, DS_ACK, DS_RD, DS_MACK
  } cgcfg_dst_t;
  // controller states and byte stages
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} cgcfg_hst_t;
  typedef enum logic [1:0] {STG_ADDR, STG_PTR, STG_DATA} cgcfg_stg_t;
  typedef struct packed {
    cgcfg_dst_t st;
    cgcfg_dst_t nxt;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic nack;
    logic scl_q;
    logic sda_q;
    logic oe;
    logic [23:0][7:0] cfg;
    logic [8:0] fb_div;
    logic fb_bad;
    logic [2:0] in_div;
    cgcfg_pscale_t ps;
    logic [6:0] odiv;
    logic od_bad;
    logic [1:0] cp;
    logic skip;
    logic [3:0] drv;
    logic [3:0] style;
  } cgcfg_dev_t;
  typedef struct packed {
    cgcfg_hst_t st;
    cgcfg_stg_t stg;
    logic [15:0] div;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rdb;
    logic ackb;
    logic rsent;
    logic [2:0] idx;
    logic [7:0] ptr;
    logic [2:0] len;
    logic rdcmd;
    logic busy;
    logic nack;
    logic done;
    logic [31:0] data;
    logic [31:0] prdata;
    logic slverr;
    logic scl;
    logic sda;
  } cgcfg_hst_st_t;
endpackage

/* hw/cgcfg_if.sv */
// cgcfg_if.sv: two-wire configuration link between controller and device
// assumes: open-drain wires with pull-ups, as wired AND
`timescale 1ns/1ps
`default_nettype none
interface cgcfg_if;
  logic scl_o;
  logic scl_oe;
  logic msda_o;
  logic msda_oe;
  logic ssda_o;
  logic ssda_oe;
  logic scl_line;
  logic serial_data_pin;
  // a released line reads high
  assign scl_line = scl_oe ? scl_o : 1'b1;
  assign serial_data_pin = (msda_oe ? msda_o : 1'b1)
    & (ssda_oe ? ssda_o : 1'b1);
  modport host (output scl_o, scl_oe, msda_o, msda_oe,
    input scl_line, serial_data_pin);
  modport dev (output ssda_o, ssda_oe, input scl_line, serial_data_pin);
endinterface // cgcfg_if
`default_nettype wire

/* hw/cgcfg_dev.sv */
// cgcfg_dev.sv: configuration slave and parameter-set decode
// assumes: link pins synchronous to clk_i, SCL far slower than clk_i
`timescale 1ns/1ps
`default_nettype none
`include "cgcfg_defines.svh"
module cgcfg_dev #(
  parameter logic [191:0] DEFAULTS = `CGCFG_CFG_RESET
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // serial link
  cgcfg_if.dev link,
  // select pins
  input wire logic [1:0] freq_set_select_i,
  input wire logic input_sel_i,
  // decoded parameters of the active set
  output logic [8:0] fb_div_o,
  output logic fb_code_bad_o,
  output logic [2:0] in_div_o,
  output cgcfg_pkg::cgcfg_pscale_t prescale_o,
  output logic [6:0] out_div_o,
  output logic out_code_bad_o,
  output logic [1:0] pump_range_code_o,
  output logic pll_skip_bit_o,
  output logic [3:0] output_drive_en_o,
  output logic [3:0] output_level_style_o
);
  import cgcfg_pkg::*;

  cgcfg_dev_t r_reg;
  cgcfg_dev_t r_next;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic [7:0] cb;
  logic [7:0] ob;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte of one set
  function automatic logic [7:0] set_byte(input logic [23:0][7:0] c,
    input logic [4:0] base, input logic [1:0] s);
    set_byte = c[base + {3'h0, s}];
  endfunction

  // byte at the pointer, zero past the map
  function automatic logic [7:0] rd_byte(input logic [23:0][7:0] c,
    input logic [7:0] p);
    rd_byte = (p < `CGCFG_NUM_BYTES) ? c[p[4:0]] : 8'h00;
  endfunction

  // four per-output bits, Q3 down to Q0
  function automatic logic [3:0] q_bits(input logic [7:0] b);
    q_bits = {b[`CGCFG_Q3_BIT], b[`CGCFG_Q2_BIT],
      b[`CGCFG_Q1_BIT], b[`CGCFG_Q0_BIT]};
  endfunction

  // output divider value from its code
  function automatic logic [6:0] odiv_dec(input logic [6:0] c);
    if (c < 7'h06)
      odiv_dec = c;
    else
      odiv_dec = {c[6:1], 1'b0};
  endfunction

  // input divider from source select and code
  function automatic logic [2:0] pdiv_dec(input logic sel,
    input logic [1:0] c);
    if (!sel)
      pdiv_dec = 3'h1;
    else
    begin
      case (c)
        2'h0: pdiv_dec = 3'h1;
        2'h1: pdiv_dec = 3'h2;
        2'h2: pdiv_dec = 3'h4;
        default: pdiv_dec = 3'h5;
      endcase
    end
  endfunction

  assign scl = link.scl_line;
  assign sda = link.serial_data_pin;
  assign rise = scl & ~r_reg.scl_q;
  assign fall = ~scl & r_reg.scl_q;
  assign cb = set_byte(r_reg.cfg, `CGCFG_BYTE_CTL, freq_set_select_i);
  assign ob = set_byte(r_reg.cfg, `CGCFG_BYTE_ODIV, freq_set_select_i);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // serial engine and decode of the selected set
  always_comb
  begin
    r_next = r_reg;
    r_next.scl_q = scl;
    r_next.sda_q = sda;
    case (r_reg.st)
      DS_ADDR, DS_PTR, DS_WR:
      begin
        if (rise)
        begin
          r_next.sh = {r_reg.sh[6:0], sda};
          r_next.bcnt = r_reg.bcnt + 4'h1;
        end
        else if (fall && r_reg.bcnt == 4'h8)
        begin
          r_next.bcnt = 4'h0;
          r_next.oe = 1'b1;
          r_next.st = DS_ACK;
          r_next.nxt = DS_WR;
          case (r_reg.st)
            DS_ADDR:
            begin
              if (r_reg.sh[7:1] == `CGCFG_SLAVE_ADDR)
                r_next.nxt = r_reg.sh[0] ? DS_RD : DS_PTR;
              else
              begin
                r_next.oe = 1'b0;
                r_next.st = DS_IDLE;
              end
            end
            DS_PTR: r_next.ptr = r_reg.sh;
            default:
            begin
              if (r_reg.ptr < `CGCFG_NUM_BYTES)
                r_next.cfg[r_reg.ptr[4:0]] = r_reg.sh;
              r_next.ptr = r_reg.ptr + 8'h01;
            end
          endcase
        end
      end
      DS_ACK:
      begin
        if (fall)
        begin
          r_next.oe = 1'b0;
          r_next.st = r_reg.nxt;
          if (r_reg.nxt == DS_RD)
          begin
            r_next.sh = rd_byte(r_reg.cfg, r_reg.ptr);
            r_next.oe = ~r_next.sh[7];
            r_next.bcnt = 4'h1;
          end
        end
      end
      DS_RD:
      begin
        if (fall)
        begin
          if (r_reg.bcnt == 4'h8)
          begin
            r_next.oe = 1'b0;
            r_next.ptr = r_reg.ptr + 8'h01;
            r_next.st = DS_MACK;
          end
          else
          begin
            r_next.oe = ~r_reg.sh[6];
            r_next.sh = {r_reg.sh[6:0], 1'b0};
            r_next.bcnt = r_reg.bcnt + 4'h1;
          end
        end
      end
      DS_MACK:
      begin
        if (rise)
          r_next.nack = sda;
        else if (fall)
        begin
          if (r_reg.nack)
            r_next.st = DS_IDLE;
          else
          begin
            r_next.sh = rd_byte(r_reg.cfg, r_reg.ptr);
            r_next.oe = ~r_next.sh[7];
            r_next.bcnt = 4'h1;
            r_next.st = DS_RD;
          end
        end
      end
      default: ;
    endcase
    // start or stop: data moves while the clock is high
    if (scl && r_reg.scl_q && sda != r_reg.sda_q)
    begin
      r_next.oe = 1'b0;
      r_next.bcnt = 4'h0;
      r_next.st = sda ? DS_IDLE : DS_ADDR;
    end
    // decode of the set picked by the pins
    r_next.fb_div = {set_byte(r_reg.cfg, `CGCFG_BYTE_FB,
      freq_set_select_i), 1'b0};
    r_next.fb_bad = (r_next.fb_div[8:1] < `CGCFG_FB_MIN)
      || (r_next.fb_div[8:1] > `CGCFG_FB_MAX);
    r_next.in_div = pdiv_dec(input_sel_i,
      cb[`CGCFG_PDIV_MSB:`CGCFG_PDIV_LSB]);
    r_next.ps = cb[`CGCFG_PS_MSB] ? PS_X2
      : (cb[`CGCFG_PS_LSB] ? PS_HALF : PS_X1);
    r_next.cp = cb[`CGCFG_CP_MSB:`CGCFG_CP_LSB];
    r_next.skip = cb[`CGCFG_SKIP_BIT];
    r_next.odiv = odiv_dec(ob[6:0]);
    r_next.od_bad = (ob[6:1] == 6'h00);
    r_next.drv = q_bits(set_byte(r_reg.cfg, `CGCFG_BYTE_OE,
      freq_set_select_i));
    r_next.style = q_bits(set_byte(r_reg.cfg, `CGCFG_BYTE_STYLE,
      freq_set_select_i));
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      r_reg <= '0;
      r_reg.scl_q <= 1'b1;
      r_reg.sda_q <= 1'b1;
      r_reg.cfg <= DEFAULTS;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.ssda_o = 1'b0;
  assign link.ssda_oe = r_reg.oe;
  assign fb_div_o = r_reg.fb_div;
  assign fb_code_bad_o = r_reg.fb_bad;
  assign in_div_o = r_reg.in_div;
  assign prescale_o = r_reg.ps;
  assign out_div_o = r_reg.odiv;
  assign out_code_bad_o = r_reg.od_bad;
  assign pump_range_code_o = r_reg.cp;
  assign pll_skip_bit_o = r_reg.skip;
  assign output_drive_en_o = r_reg.drv;
  assign output_level_style_o = r_reg.style;
endmodule // cgcfg_dev
`default_nettype wire

/* bench/cgcfg_assertions.sv */
// cgcfg_assertions.sv: protocol checks on the configuration link
// assumes: sits beside the link interface, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "cgcfg_defines.svh"
module cgcfg_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link signals
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic msda_o,
  input wire logic msda_oe,
  input wire logic ssda_o,
  input wire logic ssda_oe,
  input wire logic scl_line,
  input wire logic serial_data_pin
);
  logic scl_reg, sda_reg, first_reg, mine_reg, rd_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic rise, start, stop, slot;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------
  // frame tracker
  // ----------------------------------------------------------------
  assign rise = !scl_reg && scl_line;
  assign start = scl_reg && scl_line && sda_reg && !serial_data_pin;
  assign stop = scl_reg && scl_line && !sda_reg && serial_data_pin;
  assign slot = rise && cnt_reg == 4'h8;
  // bit count, address byte and direction
  always_ff @(posedge clk_i)
  begin
    scl_reg <= scl_line;
    sda_reg <= serial_data_pin;
    if (!rstn_i || stop)
    begin
      cnt_reg <= 4'h0;
      first_reg <= 1'b0;
      mine_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= 4'h0;
      first_reg <= 1'b1;
    end
    else if (slot)
    begin
      cnt_reg <= 4'h0;
      first_reg <= 1'b0;
      if (first_reg)
      begin
        mine_reg <= sh_reg[7:1] == `CGCFG_SLAVE_ADDR;
        rd_reg <= sh_reg[0];
      end
    end
    else if (rise)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      sh_reg <= {sh_reg[6:0], serial_data_pin};
    end
  end
  property p_addr_ack;
    slot && first_reg && sh_reg[7:1] == `CGCFG_SLAVE_ADDR |-> !serial_data_pin;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_data_ack;
    slot && !first_reg && mine_reg && !rd_reg |-> !serial_data_pin;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("byte not acked");
  property p_rd_rel;
    slot && !first_reg && mine_reg && rd_reg |-> !ssda_oe;
  endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("master ack blocked");
  property p_hold;
    scl_reg && scl_line |-> $stable(ssda_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved on high clock");
  property p_rx_quiet;
    rise && cnt_reg != 4'h8 && (first_reg || !rd_reg) |-> !ssda_oe;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("driven in rx bit");
  property p_stop_rel;
    stop |=> !ssda_oe [*4];
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("driven after stop");
  property p_start_rel;
    start |-> !ssda_oe;
  endproperty
  a_start_rel: assert property (p_start_rel) else $error("start by device");
  property p_open;
    !(scl_oe && scl_o) && !(msda_oe && msda_o) && !(ssda_oe && ssda_o);
  endproperty
  a_open: assert property (p_open) else $error("line driven high");
  c_read: cover property (slot && first_reg && sh_reg[0]);
  c_write: cover property (slot && !first_reg && mine_reg && !rd_reg);
  c_stop: cover property (stop);
endmodule // cgcfg_assertions
`default_nettype wire

/* bench/cgcfg_test.sv */
// cgcfg_test.sv: self-checking bench, controller and device on one link
// assumes: package, interface and both ends compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cgcfg_defines.svh"
module cgcfg_test;
  import cgcfg_pkg::*;
  typedef struct {string what; logic [33:0] v;} cgcfg_note_t;
  localparam int QTR = 4;
  localparam logic [191:0] DEF = `CGCFG_CFG_RESET;
  logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic input_sel_i, look, seen;
  logic [1:0] freq_set_select_i, src;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, lfsr_reg;
  logic [7:0] cfg [24];
  logic [33:0] obs;
  wire logic [33:0] dec_vec;
  int failures, tests_run;
  cgcfg_note_t notes [$];
  cgcfg_note_t n;
  cgcfg_if lnk ();
  cgcfg_if lnk2 ();
  cgcfg_host #(.QTR_CYC(QTR)) i_cgcfg_host (.clk_i, .rstn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .link(lnk));
  cgcfg_dev i_cgcfg_dev (.clk_i, .rstn_i, .link(lnk), .freq_set_select_i,
    .input_sel_i, .fb_div_o(dec_vec[33:25]), .fb_code_bad_o(dec_vec[24]),
    .in_div_o(dec_vec[23:21]), .prescale_o(dec_vec[20:19]),
    .out_div_o(dec_vec[18:12]), .out_code_bad_o(dec_vec[11]),
    .pump_range_code_o(dec_vec[10:9]), .pll_skip_bit_o(dec_vec[8]),
    .output_drive_en_o(dec_vec[7:4]), .output_level_style_o(dec_vec[3:0]));
  cgcfg_dev i_cgcfg_dev_b (.clk_i, .rstn_i, .link(lnk2), .freq_set_select_i,
    .input_sel_i, .fb_div_o(), .fb_code_bad_o(), .in_div_o(), .prescale_o(),
    .out_div_o(), .out_code_bad_o(), .pump_range_code_o(),
    .pll_skip_bit_o(), .output_drive_en_o(), .output_level_style_o());
  cgcfg_assertions i_cgcfg_assertions (.clk_i, .rstn_i,
    .scl_o(lnk.scl_o), .scl_oe(lnk.scl_oe), .msda_o(lnk.msda_o),
    .msda_oe(lnk.msda_oe), .ssda_o(lnk.ssda_o), .ssda_oe(lnk.ssda_oe),
    .scl_line(lnk.scl_line), .serial_data_pin(lnk.serial_data_pin));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected decode of one set
  function automatic logic [33:0] dec(input int s, input logic isel);
    logic [7:0] f, o, c, st, e;
    logic [2:0] p;
    f = cfg[s];
    o = cfg[4 + s];
    c = cfg[8 + s];
    st = cfg[12 + s];
    e = cfg[16 + s];
    p = !isel ? 3'h1 : c[3] ? (c[2] ? 3'h5 : 3'h4) : (c[2] ? 3'h2 : 3'h1);
    return {f, 1'b0, f < `CGCFG_FB_MIN || f > `CGCFG_FB_MAX, p,
      c[5] ? 2'h2 : {1'b0, c[4]}, o[6:0] < 7'h06 ? o[6:0] : {o[6:1], 1'b0},
      o[6:1] == 6'h00, c[1:0], c[6], e[6], e[5], e[2], e[1], st[6], st[5],
      st[2], st[1]};
  endfunction
  task automatic check(input logic [33:0] got, input logic [33:0] exp,
    input string what);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // setup, then access until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // queue a note, pulse the watcher
  task automatic look_at(input logic [1:0] s, input string w,
    input logic [33:0] v);
    notes.push_back('{w, v});
    src <= s;
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk_dec(input int s, input logic i);
    freq_set_select_i <= s[1:0];
    input_sel_i <= i;
    repeat (3) @(posedge clk_i);
    look_at(2'h1, "decode", dec(s, i));
  endtask
  // one block transfer, waits for done
  task automatic xfer(input logic r, input logic [7:0] p, input logic [2:0] len,
    input logic [31:0] d);
    if (!r)
      apb(1'b1, `CGCFG_OFS_DATA, d);
    apb(1'b1, `CGCFG_OFS_CMD, {1'b1, 14'h0, r, 5'h0, len, p});
    rd = 32'h0;
    while (rd[2] !== 1'b1)
      apb(1'b0, `CGCFG_OFS_STAT, 32'h0);
    look_at(2'h0, "status", 34'h4);
    for (int i = 0; i < len; i++)
      if (!r && p + i < 24)
        cfg[p + i] = d[8 * i +: 8];
  endtask
  task automatic rdchk(input logic [7:0] p, input logic [31:0] e);
    xfer(1'b1, p, 3'h4, 32'h0);
    apb(1'b0, `CGCFG_OFS_DATA, 32'h0);
    look_at(2'h0, "read", {2'h0, e});
  endtask
  // second link: one quarter bit
  task automatic bb(input logic d, input logic c);
    lnk2.msda_oe <= !d;
    lnk2.scl_oe <= !c;
    repeat (QTR) @(posedge clk_i);
  endtask
  task automatic bb_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      bb(b[i], 1'b0);
      bb(b[i], 1'b1);
      bb(b[i], 1'b0);
    end
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    seen = lnk2.serial_data_pin;
    bb(1'b1, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // watcher, clock, watchdog and main sequence
  // ----------------------------------------------------------------
  assign obs = src == 2'h0 ? {1'b0, pslverr_o, prdata_o}
    : src == 2'h1 ? dec_vec : {33'h0, seen};
  // compare with the oldest note
  always @(posedge clk_i)
    if (look === 1'b1)
    begin
      n = notes.pop_front();
      check(obs, n.v, n.what);
    end
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (90000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
  initial
  begin
    {rstn_i, psel_i, penable_i, pwrite_i, input_sel_i, look} = 6'h0;
    {freq_set_select_i, src, paddr_i, pwdata_i} = 44'h0;
    {lnk2.scl_o, lnk2.scl_oe, lnk2.msda_o, lnk2.msda_oe} = 4'h0;
    lfsr_reg = 32'hD94E;
    seen = 1'b1;
    for (int i = 0; i < 24; i++)
      cfg[i] = DEF[8 * i +: 8];
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 8; k++)
      chk_dec(k / 2, k[0]);
    xfer(1'b0, 8'h00, 3'h4, 32'h7E7D0807);
    xfer(1'b0, 8'h04, 3'h4, 32'h7F070502);
    xfer(1'b0, 8'h08, 3'h4, 32'h3E6A1440);
    for (int p = 12; p < 20; p += 4)
    begin
      lfsr_reg = lfsr(lfsr_reg);
      xfer(1'b0, p[7:0], 3'h4, lfsr_reg);
    end
    for (int k = 0; k < 8; k++)
      chk_dec(k / 2, k[0]);
    rdchk(8'h08, {cfg[11], cfg[10], cfg[9], cfg[8]});
    rdchk(8'h16, {16'h0, cfg[23], cfg[22]});
    xfer(1'b0, 8'h14, 3'h2, 32'hFFFF5AA5);
    rdchk(8'h14, {cfg[23], cfg[22], cfg[21], cfg[20]});
    apb(1'b0, 8'h0C, 32'h0);
    look_at(2'h0, "unmapped", 34'h1_0000_0000);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    bb_byte(8'hDE);
    look_at(2'h2, "foreign", 34'h1);
    bb_byte(8'h00);
    look_at(2'h2, "ignored", 34'h1);
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    bb_byte(8'hDC);
    look_at(2'h2, "own", 34'h0);
    bb_byte(8'h05);
    look_at(2'h2, "pointer", 34'h0);
    tally_and_finish();
  end
endmodule // cgcfg_test
`default_nettype wire
